// File: rtl/mim_defs.svh
// register offsets, field positions, reset values and write masks
// for the metering interrupt flag and mask block
// assumes the host port hands over word-wide accesses by register offset
`ifndef MIM_DEFS_SVH
`define MIM_DEFS_SVH

// register offsets (word index on the host port)
`define MIM_STATUS_OFFSET   16'h0404
`define MIM_MASK_OFFSET     16'h0405

// field positions shared by status and mask words; bits 2 and 0 are status only
`define MIM_BIT_CHIP_SUM     31
`define MIM_BIT_EVENT_SUM    30
`define MIM_BIT_AUTOCAL_SUM  29
`define MIM_BIT_POWER_FACTOR_READY       25
`define MIM_BIT_CKS_CHG      24
`define MIM_BIT_CKS_DONE     23
`define MIM_BIT_ZX_TIMEOUT   21
`define MIM_BIT_ZX_CUR_B     20
`define MIM_BIT_ZX_CUR_A     19
`define MIM_BIT_ZX_VOLT      17
`define MIM_BIT_NL_REACT     15
`define MIM_BIT_NL_APPAR     14
`define MIM_BIT_NL_ACTIVE    13
`define MIM_BIT_TEMP_RDY     12
`define MIM_BIT_RMS_RDY      11
`define MIM_BIT_PWR_RDY      10
`define MIM_BIT_WAVE_RDY     9
`define MIM_BIT_EGY_RDY      8
`define MIM_BIT_FO2_PULSE    7
`define MIM_BIT_FO1_PULSE    6
`define MIM_BIT_FO2_FLIP     5
`define MIM_BIT_REACT_FLIP   2
`define MIM_BIT_ACTIVE_FLIP  0

// reset values
`define MIM_MASK_RESET      32'h0000_0000
`define MIM_STATUS_RESET    32'h0000_0000
`define MIM_RDATA_RESET     32'h0000_0000

// writable mask positions; every other position reads zero
`define MIM_MASK_WMASK      32'hE3BA_FFE0
// status positions that latch until written with one
`define MIM_STATUS_STICKY   32'h03BA_FFE5
// status positions that mirror live summary levels
`define MIM_STATUS_LIVE     32'hE000_0000

`endif

// File: rtl/mim_pkg.sv
// types for the metering interrupt flag and mask block
// assumes mim_defs.svh supplies all offsets and bit positions
package mim_pkg;

   // one-cycle event strobes from the metrology engine
   typedef struct packed {
      logic power_factor_ready;       // power factor refreshed
      logic config_checksum_changed;  // monitored config changed
      logic config_checksum_done;     // forced checksum finished
      logic voltage_crossing_timeout; // voltage crossing missing
      logic current_b_crossing;       // current b zero crossing
      logic current_a_crossing;       // current a zero crossing
      logic voltage_crossing;         // voltage zero crossing
      logic reactive_noload_change;   // reactive no-load edge
      logic apparent_noload_change;   // apparent no-load edge
      logic active_noload_change;     // active no-load edge
      logic temp_ready;               // temperature result fresh
      logic halfcycle_rms_ready;      // half-cycle rms refreshed
      logic power_accum_ready;        // power accumulators refreshed
      logic waveform_ready;           // waveform samples ready
      logic energy_ready;             // energy registers refreshed
   } mim_events_s;

   // live summary levels of the other status registers
   typedef struct packed {
      logic chip_any;     // any chip status flag set
      logic event_any;    // any event status flag set
      logic autocal_any;  // any autocal irq flag set
   } mim_summary_s;

   // register port request from the serial host port
   typedef struct packed {
      logic        wr;     // write strobe, one cycle
      logic        rd;     // read strobe, one cycle
      logic [15:0] addr;   // register offset
      logic [31:0] wdata;  // write data
   } mim_req_s;

endpackage : mim_pkg

// File: rtl/mim_sign_flip.sv
// sign change detector for a set of power channels
// assumes strobe marks the accumulator refresh and sign is valid then
`timescale 1ns/1ps
module mim_sign_flip #(
   parameter int WIDTH = 2                 // number of channels
) (
   input  wire logic             clk,      // metrology clock
   input  wire logic             reset,    // sync reset, active high
   input  wire logic             strobe,   // accumulator refresh
   input  wire logic [WIDTH-1:0] sign,     // one when negative
   output logic      [WIDTH-1:0] flip_r    // sign changed, one cycle
);
   // refuse an empty channel set at elaboration
   if (WIDTH < 1) begin : g_bad_width
      $error("mim_sign_flip: WIDTH must be positive");
   end

   logic seen_r;  // a first sign has been captured

   // first refresh only captures; later ones compare
   always_ff @(posedge clk) begin
      if (reset) begin
         seen_r <= 1'b0;
      end else if (strobe) begin
         seen_r <= 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_chan
         logic last_r;  // sign at previous refresh
         always_ff @(posedge clk) begin
            if (reset) begin
               last_r   <= 1'b0;
               flip_r[g] <= 1'b0;
            end else begin
               flip_r[g] <= strobe && seen_r && (sign[g] != last_r);
               if (strobe) last_r <= sign[g];
            end
         end
      end
   endgenerate
endmodule : mim_sign_flip

// File: rtl/mim_pulse_watch.sv
// frequency output pulse watcher: high-to-low edge and polarity change
// assumes pin and polarity levels are synchronous to clk
`timescale 1ns/1ps
module mim_pulse_watch (
   input  wire logic clk,      // metrology clock
   input  wire logic reset,    // sync reset, active high
   input  wire logic pin,      // frequency output pin level
   input  wire logic neg,      // energy polarity of this pulse
   output logic      fall_r,   // pulse issued, one cycle
   output logic      flip_r    // polarity changed, one cycle
);
   logic pin_q_r;   // pin one cycle ago
   logic pol_r;     // polarity of last pulse
   logic seen_r;    // a pulse has been seen
   logic fall;      // high-to-low edge now

   assign fall = pin_q_r && !pin;

   // pin history; reset high so no false edge
   always_ff @(posedge clk) begin
      if (reset) pin_q_r <= 1'b1;
      else       pin_q_r <= pin;
   end

   // edge pulse and polarity compare at each issued pulse
   always_ff @(posedge clk) begin
      if (reset) begin
         fall_r <= 1'b0;
         flip_r <= 1'b0;
         pol_r  <= 1'b0;
         seen_r <= 1'b0;
      end else begin
         fall_r <= fall;
         flip_r <= fall && seen_r && (neg != pol_r);
         if (fall) begin
            pol_r  <= neg;
            seen_r <= 1'b1;
         end
      end
   end
endmodule : mim_pulse_watch

// File: rtl/mim_top.sv
// interrupt status flags, enable mask and interrupt output
// of a single-phase metering core
// assumes event strobes are one-cycle pulses on clk, and that the host
// port delivers decoded word accesses with one-cycle strobes
`timescale 1ns/1ps
`include "mim_defs.svh"

// Contract
// R1: status bit 2 flags reactive sign change
// R2: status bit 0 flags active sign change
// R3: mask 31 enables chip status summary
// R4: mask 30 enables event status summary
// R5: mask 29 enables autocal status summary
// R6: mask 25 enables power factor refresh
// R7: mask 24 enables config checksum change
// R8: mask 23 enables forced checksum done
// R9: mask 21 enables voltage crossing timeout
// R10: masks 20,19,17 enable zero crossings
// R11: masks 15,14,13 enable no-load changes
// R12: mask 12 enables temperature ready
// R13: mask 11 enables half-cycle rms ready
// R14: mask 10 enables power accumulator refresh
// R15: mask 9 enables waveform ready
// R16: mask 8 enables energy refresh
// R17: masks 7,6 enable frequency output pulses
// R18: mask 5 enables second output sign flip
// R19: flags other than summaries 31..29 sticky until host writes one
// R20: irq active while any enabled flag
// R21: mask resets zero, reserved bits stay zero
module mim_top
   import mim_pkg::*;
#(
   parameter int DATA_W = 32,   // register width
   parameter int ADDR_W = 16    // offset width
) (
   input  wire logic             clk,           // metrology clock
   input  wire logic             reset,         // sync reset, high
   input  wire mim_pkg::mim_req_s req,          // host register access
   input  wire mim_pkg::mim_events_s events,    // metrology strobes
   input  wire mim_pkg::mim_summary_s summary,  // summary levels
   input  wire logic             active_neg,    // active power < 0
   input  wire logic             reactive_neg,  // reactive power < 0
   input  wire logic             freq_out_one_pulse, // output 1 pin
   input  wire logic             freq_out_two_pulse, // output 2 pin
   input  wire logic             freq_out_two_neg,   // output 2 sign
   output logic      [DATA_W-1:0] rdata_r,      // read data
   output logic                  rvalid_r,      // read data valid
   output logic                  irq_r,         // interrupt, high
   output logic      [DATA_W-1:0] status_r,     // status word view
   output logic      [DATA_W-1:0] mask_r        // mask word view
);
   import mim_pkg::*;

   // refuse widths the fixed bit map cannot serve
   if (DATA_W != 32) begin : g_bad_data
      $error("mim_top: DATA_W must be 32");
   end
   if (ADDR_W != 16) begin : g_bad_addr
      $error("mim_top: ADDR_W must be 16");
   end

   // event sources
   logic [1:0] sign_flip;   // [1] reactive, [0] active
   logic       fo1_fall;    // output 1 pulse issued
   logic       fo2_fall;    // output 2 pulse issued
   logic       fo2_flip;    // output 2 polarity change

   // sign compare at each power accumulator refresh
   mim_sign_flip #(
      .WIDTH (2)
   ) u_sign (
      .clk    (clk),
      .reset  (reset),
      .strobe (events.power_accum_ready),
      .sign   ({reactive_neg, active_neg}),
      .flip_r (sign_flip)
   );

   // first frequency output watcher
   mim_pulse_watch u_fo1 (
      .clk    (clk),
      .reset  (reset),
      .pin    (freq_out_one_pulse),
      .neg    (1'b0),
      .fall_r (fo1_fall),
      .flip_r ()   // output one polarity is not served
   );

   // second frequency output watcher
   mim_pulse_watch u_fo2 (
      .clk    (clk),
      .reset  (reset),
      .pin    (freq_out_two_pulse),
      .neg    (freq_out_two_neg),
      .fall_r (fo2_fall),
      .flip_r (fo2_flip)
   );

   // set and clear vectors
   logic [31:0] set_vec;     // events landing this cycle
   logic [31:0] live_vec;    // live summary levels
   logic [31:0] clr_vec;     // write-one-to-clear positions
   logic        wr_status;   // write to status word
   logic        wr_mask;     // write to mask word
   logic        rd_status;   // read of status word
   logic        rd_mask;     // read of mask word

   // address decode
   assign wr_status = req.wr && (req.addr == `MIM_STATUS_OFFSET);
   assign wr_mask   = req.wr && (req.addr == `MIM_MASK_OFFSET);
   assign rd_status = req.rd && (req.addr == `MIM_STATUS_OFFSET);
   assign rd_mask   = req.rd && (req.addr == `MIM_MASK_OFFSET);

   // map each event onto its flag position
   always_comb begin
      set_vec = 32'h0000_0000;
      set_vec[`MIM_BIT_REACT_FLIP]  = sign_flip[1];                // R1
      set_vec[`MIM_BIT_ACTIVE_FLIP] = sign_flip[0];                // R2
      set_vec[`MIM_BIT_POWER_FACTOR_READY]      = events.power_factor_ready;   // R6
      set_vec[`MIM_BIT_CKS_CHG] = events.config_checksum_changed;  // R7
      set_vec[`MIM_BIT_CKS_DONE] = events.config_checksum_done;    // R8
      set_vec[`MIM_BIT_ZX_TIMEOUT] = events.voltage_crossing_timeout; // R9
      set_vec[`MIM_BIT_ZX_CUR_B] = events.current_b_crossing;      // R10
      set_vec[`MIM_BIT_ZX_CUR_A] = events.current_a_crossing;      // R10
      set_vec[`MIM_BIT_ZX_VOLT]  = events.voltage_crossing;        // R10
      set_vec[`MIM_BIT_NL_REACT] = events.reactive_noload_change;  // R11
      set_vec[`MIM_BIT_NL_APPAR] = events.apparent_noload_change;  // R11
      set_vec[`MIM_BIT_NL_ACTIVE] = events.active_noload_change;   // R11
      set_vec[`MIM_BIT_TEMP_RDY] = events.temp_ready;              // R12
      set_vec[`MIM_BIT_RMS_RDY]  = events.halfcycle_rms_ready;     // R13
      set_vec[`MIM_BIT_PWR_RDY]  = events.power_accum_ready;       // R14
      set_vec[`MIM_BIT_WAVE_RDY] = events.waveform_ready;          // R15
      set_vec[`MIM_BIT_EGY_RDY]  = events.energy_ready;            // R16
      set_vec[`MIM_BIT_FO2_PULSE] = fo2_fall;                      // R17
      set_vec[`MIM_BIT_FO1_PULSE] = fo1_fall;                      // R17
      set_vec[`MIM_BIT_FO2_FLIP] = fo2_flip;                       // R18
   end

   // summary levels are mirrored, not latched
   always_comb begin
      live_vec = 32'h0000_0000;
      live_vec[`MIM_BIT_CHIP_SUM]    = summary.chip_any;      // R3
      live_vec[`MIM_BIT_EVENT_SUM]   = summary.event_any;     // R4
      live_vec[`MIM_BIT_AUTOCAL_SUM] = summary.autocal_any;   // R5
   end

   // a write of one clears only sticky positions
   assign clr_vec = wr_status ? (req.wdata & `MIM_STATUS_STICKY)
                              : 32'h0000_0000;

   // next state
   logic [31:0] sticky_r;    // latched flags
   logic [31:0] sticky_nxt;  // flags after set and clear
   logic [31:0] mask_nxt;    // mask after write
   logic [31:0] status_nxt;  // word seen by host and irq

   // set wins over a clear in the same cycle
   assign sticky_nxt = ((sticky_r & ~clr_vec) | set_vec)
                       & `MIM_STATUS_STICKY;                       // R19

   // reserved and out-of-block positions never take a one
   assign mask_nxt = wr_mask ? (req.wdata & `MIM_MASK_WMASK)
                             : mask_r;                             // R21

   assign status_nxt = sticky_nxt | (live_vec & `MIM_STATUS_LIVE);

   // registers
   // sticky status flags
   always_ff @(posedge clk) begin
      if (reset) sticky_r <= `MIM_STATUS_RESET;
      else       sticky_r <= sticky_nxt;                           // R19
   end

   // status word view, live bits included
   always_ff @(posedge clk) begin
      if (reset) status_r <= `MIM_STATUS_RESET;
      else       status_r <= status_nxt;
   end

   // interrupt enable mask
   always_ff @(posedge clk) begin
      if (reset) mask_r <= `MIM_MASK_RESET;                        // R21
      else       mask_r <= mask_nxt;
   end

   // interrupt follows the same state the host will read
   always_ff @(posedge clk) begin
      if (reset) irq_r <= 1'b0;
      else       irq_r <= |(status_nxt & mask_nxt);                // R20
   end

   // read data: one cycle after the strobe, zero for other offsets
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_r  <= `MIM_RDATA_RESET;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= req.rd;
         if (rd_status)    rdata_r <= status_r;
         else if (rd_mask) rdata_r <= mask_r;
         else if (req.rd)  rdata_r <= 32'h0000_0000;
      end
   end

   // checks
   // helper: previous-cycle event and clear views
   logic [31:0] set_q_r;   // set vector one cycle ago
   logic [31:0] clr_q_r;   // clear vector one cycle ago
   always_ff @(posedge clk) begin
      if (reset) begin
         set_q_r <= 32'h0000_0000;
         clr_q_r <= 32'h0000_0000;
      end else begin
         set_q_r <= set_vec;
         clr_q_r <= clr_vec;
      end
   end

   // a power refresh that carries a reactive sign change
   sequence react_change_s;
      events.power_accum_ready && u_sign.seen_r
         && (reactive_neg != u_sign.g_chan[1].last_r);
   endsequence

   sequence active_change_s;
      events.power_accum_ready && u_sign.seen_r
         && (active_neg != u_sign.g_chan[0].last_r);
   endsequence

   // output two pin sampled high, then low
   sequence fo2_fall_s;
      freq_out_two_pulse ##1 !freq_out_two_pulse;
   endsequence

   // output two pulse whose polarity differs from the last one
   sequence fo2_turn_s;
      freq_out_two_pulse ##1 (!freq_out_two_pulse && u_fo2.seen_r
         && (freq_out_two_neg != u_fo2.pol_r));
   endsequence

   react_flip_a: assert property (@(posedge clk) disable iff (reset) // R1
      react_change_s |-> ##2 status_r[`MIM_BIT_REACT_FLIP])
      else $error("reactive sign change not flagged");

   active_flip_a: assert property (@(posedge clk) disable iff (reset) // R2
      active_change_s |-> ##2 status_r[`MIM_BIT_ACTIVE_FLIP])
      else $error("active sign change not flagged");

   summary_irq_a: assert property (@(posedge clk) disable iff (reset) // R3
      (summary.chip_any && mask_nxt[`MIM_BIT_CHIP_SUM]) |=> irq_r)
      else $error("chip summary did not raise irq");

   event_irq_a: assert property (@(posedge clk) disable iff (reset) // R4
      (summary.event_any && mask_nxt[`MIM_BIT_EVENT_SUM]) |=> irq_r)
      else $error("event summary did not raise irq");

   autocal_irq_a: assert property (@(posedge clk) disable iff (reset) // R5
      (summary.autocal_any && mask_nxt[`MIM_BIT_AUTOCAL_SUM]) |=> irq_r)
      else $error("autocal summary did not raise irq");

   event_set_a: assert property (@(posedge clk) disable iff (reset) // R6
      (events.power_factor_ready || events.energy_ready)
      |=> (status_r[`MIM_BIT_POWER_FACTOR_READY] || status_r[`MIM_BIT_EGY_RDY]))
      else $error("ready event not latched");

   pf_set_a: assert property (@(posedge clk) disable iff (reset) // R6
      events.power_factor_ready |=> status_r[`MIM_BIT_POWER_FACTOR_READY])
      else $error("power factor flag missed");

   cks_chg_a: assert property (@(posedge clk) disable iff (reset) // R7
      events.config_checksum_changed |=> status_r[`MIM_BIT_CKS_CHG])
      else $error("checksum change flag missed");

   cks_done_a: assert property (@(posedge clk) disable iff (reset) // R8
      events.config_checksum_done |=> status_r[`MIM_BIT_CKS_DONE])
      else $error("checksum done flag missed");

   zx_timeout_a: assert property (@(posedge clk) disable iff (reset) // R9
      events.voltage_crossing_timeout |=> status_r[`MIM_BIT_ZX_TIMEOUT])
      else $error("crossing timeout flag missed");

   crossing_set_a: assert property (@(posedge clk) disable iff (reset) // R10
      events.voltage_crossing |=> status_r[`MIM_BIT_ZX_VOLT])
      else $error("voltage crossing not latched");

   cur_b_cross_a: assert property (@(posedge clk) disable iff (reset) // R10
      events.current_b_crossing |=> status_r[`MIM_BIT_ZX_CUR_B])
      else $error("current b crossing flag missed");

   noload_set_a: assert property (@(posedge clk) disable iff (reset) // R11
      events.reactive_noload_change |=> status_r[`MIM_BIT_NL_REACT])
      else $error("no-load change flag missed");

   temp_set_a: assert property (@(posedge clk) disable iff (reset) // R12
      events.temp_ready |=> status_r[`MIM_BIT_TEMP_RDY])
      else $error("temperature flag missed");

   rms_set_a: assert property (@(posedge clk) disable iff (reset) // R13
      events.halfcycle_rms_ready |=> status_r[`MIM_BIT_RMS_RDY])
      else $error("half-cycle rms flag missed");

   pwr_set_a: assert property (@(posedge clk) disable iff (reset) // R14
      events.power_accum_ready |=> status_r[`MIM_BIT_PWR_RDY])
      else $error("power refresh flag missed");

   wave_set_a: assert property (@(posedge clk) disable iff (reset) // R15
      events.waveform_ready |=> status_r[`MIM_BIT_WAVE_RDY])
      else $error("waveform flag missed");

   egy_set_a: assert property (@(posedge clk) disable iff (reset) // R16
      events.energy_ready |=> status_r[`MIM_BIT_EGY_RDY])
      else $error("energy flag missed");

   pulse_edge_a: assert property (@(posedge clk) disable iff (reset) // R17
      fo2_fall_s |-> ##2 status_r[`MIM_BIT_FO2_PULSE])
      else $error("output two pulse not latched");

   fo2_turn_a: assert property (@(posedge clk) disable iff (reset) // R18
      fo2_turn_s |-> ##2 status_r[`MIM_BIT_FO2_FLIP])
      else $error("output two polarity change missed");

   flag_hold_a: assert property (@(posedge clk) disable iff (reset) // R19
      ($past(sticky_r) != 32'h0000_0000) && (clr_q_r == 32'h0000_0000)
      |-> ((sticky_r & $past(sticky_r)) == $past(sticky_r)))
      else $error("sticky flag dropped without a clear");

   set_wins_a: assert property (@(posedge clk) disable iff (reset) // R19
      ((set_vec & clr_vec) != 32'h0000_0000)
      |=> ((sticky_r & $past(set_vec)) == $past(set_vec)))
      else $error("clear beat a same-cycle set");

   clear_works_a: assert property (@(posedge clk) disable iff (reset) // R19
      ((clr_vec & ~set_vec) != 32'h0000_0000)
      |=> ((sticky_r & clr_q_r & ~set_q_r) == 32'h0000_0000))
      else $error("written flag not cleared");

   irq_match_a: assert property (@(posedge clk) disable iff (reset) // R20
      irq_r == |(status_r & mask_r))
      else $error("irq disagrees with status and mask");

   mask_rsvd_a: assert property (@(posedge clk) disable iff (reset) // R21
      ((mask_r & ~`MIM_MASK_WMASK) == 32'h0000_0000))
      else $error("reserved mask bit set");

   read_lat_a: assert property (@(posedge clk) disable iff (reset) // R21
      rd_mask |=> (rvalid_r && rdata_r == $past(mask_r)))
      else $error("mask readback wrong");

endmodule : mim_top

// File: dv/mim_host_model.sv
// host model: issues word accesses to the flag and mask block
// assumes the block takes one-cycle strobes on the rising clock edge
`timescale 1ns/1ps
module mim_host_model (
   input  wire logic         clk,   // metrology clock
   output mim_pkg::mim_req_s req    // register access to block
);
   import mim_pkg::*;

   // idle at time zero
   initial req = '0;

   // one access; a random idle gap models a slow host
   task automatic access(input logic        wr,
                         input logic [15:0] addr,
                         input logic [31:0] wdata);
      repeat ($urandom_range(2)) @(posedge clk);
      @(posedge clk);
      #1;
      req = '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
      @(posedge clk);
      #1;
      // released lines show the inverse, not the last value
      req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
   endtask : access
endmodule : mim_host_model

// File: dv/testbench.sv
// self-checking bench for the interrupt flag and mask block
// assumes the host model drives the register port of the top module
`timescale 1ns/1ps
`include "mim_defs.svh"
module testbench;
   import mim_pkg::*;
   logic        clk, reset;            // clock and sync reset
   mim_req_s    req;                   // host access
   mim_events_s events;                // event strobes
   mim_summary_s summary;              // summary levels
   logic        active_neg, reactive_neg; // power signs
   logic        freq_out_one_pulse, freq_out_two_pulse; // output pins
   logic        freq_out_two_neg;      // output two polarity
   logic [31:0] rdata_r, status_r, mask_r; // read data and views
   logic        rvalid_r, irq_r;       // read valid, interrupt
   logic [31:0] exp_q[$];              // expected read data
   int          n_mismatch = 0;        // mismatches seen
   int          comparisons = 0;       // comparisons made
   int          pos[15] = '{25, 24, 23, 21, 20, 19, 17, 15, 14, 13,
                            12, 11, 10, 9, 8}; // status bit per event
   logic        pa, pr, a, r, pn, n, first; // sign tracking

   mim_top dut (.clk(clk), .reset(reset), .req(req), .events(events),
      .summary(summary), .active_neg(active_neg),
      .reactive_neg(reactive_neg),
      .freq_out_one_pulse(freq_out_one_pulse),
      .freq_out_two_pulse(freq_out_two_pulse),
      .freq_out_two_neg(freq_out_two_neg), .rdata_r(rdata_r),
      .rvalid_r(rvalid_r), .irq_r(irq_r), .status_r(status_r),
      .mask_r(mask_r));
   mim_host_model host (.clk(clk), .req(req));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // verdict and end of run
   task automatic complete_run;
      if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   // compare one read word
   task automatic check_word(input logic [31:0] got, input logic [31:0] e);
      comparisons++;
      if (got !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t read %h exp %h", $time, got, e);
      end
   endtask : check_word

   // compare the interrupt level
   task automatic check_irq(input logic e);
      comparisons++;
      if (irq_r !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t irq %h exp %h", $time, irq_r, e);
      end
   endtask : check_irq

   // advance to just after a rising edge
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick

   // register write and expected read
   task automatic wr(input logic [15:0] ad, input logic [31:0] d);
      host.access(1'b1, ad, d);
   endtask : wr
   task automatic rd_exp(input logic [15:0] ad, input logic [31:0] e);
      exp_q.push_back(e);
      host.access(1'b0, ad, 32'h0000_0000);
   endtask : rd_exp

   // one-cycle event strobe, then let flags settle
   task automatic fire(input int b);
      events[b] = 1'b1;
      tick(1);
      events = '0;
      tick(2);
   endtask : fire

   // monitor: each read answer takes the oldest note
   always @(negedge clk) begin
      if (rvalid_r === 1'b1) begin
         if (exp_q.size() > 0) check_word(rdata_r, exp_q.pop_front());
         else check_word({31'h0, rvalid_r}, 32'h0000_0000);
      end
   end

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end

   // main sequence
   initial begin
      void'($urandom(32'hC1B0));
      reset = 1'b1;
      events = '0;
      summary = '0;
      {active_neg, reactive_neg, freq_out_two_neg} = 3'h0;
      {freq_out_one_pulse, freq_out_two_pulse} = 2'h3;
      tick(3);
      reset = 1'b0;
      rd_exp(`MIM_MASK_OFFSET, `MIM_MASK_RESET);
      wr(`MIM_MASK_OFFSET, 32'hFFFF_FFFF);
      check_word(mask_r, `MIM_MASK_WMASK);
      rd_exp(`MIM_MASK_OFFSET, `MIM_MASK_WMASK);
      rd_exp(16'h0406, 32'h0000_0000);
      // every event, once masked off and once enabled
      for (int i = 0; i < 30; i++) begin
         wr(`MIM_MASK_OFFSET, {31'h0, i[0]} << pos[i / 2]);
         fire(14 - i / 2);
         check_word(status_r, 32'h1 << pos[i / 2]);
         check_irq(i[0]);
         rd_exp(`MIM_STATUS_OFFSET, 32'h1 << pos[i / 2]);
         wr(`MIM_STATUS_OFFSET, 32'h1 << pos[i / 2]);
         check_irq(1'b0);
         rd_exp(`MIM_STATUS_OFFSET, 32'h0000_0000);
      end
      // event held across a clear of its own flag: the set wins
      events.temp_ready = 1'b1;
      wr(`MIM_STATUS_OFFSET, 32'h1 << `MIM_BIT_TEMP_RDY);
      events = '0;
      rd_exp(`MIM_STATUS_OFFSET, 32'h1 << `MIM_BIT_TEMP_RDY);
      wr(`MIM_STATUS_OFFSET, 32'hFFFF_FFFF);
      // summary levels of the other status registers
      for (int k = 0; k < 3; k++) begin
         wr(`MIM_MASK_OFFSET, 32'h1 << (29 + k));
         summary = 3'(1 << k);
         tick(2);
         check_irq(1'b1);
         rd_exp(`MIM_STATUS_OFFSET, 32'h1 << (29 + k));
         summary = '0;
         tick(2);
         check_irq(1'b0);
      end
      // power sign changes at accumulator refresh
      {pa, pr} = 2'h0;
      for (int k = 0; k < 6; k++) begin
         a = 1'($urandom_range(1));
         r = 1'($urandom_range(1));
         {active_neg, reactive_neg} = {a, r};
         fire(2);
         rd_exp(`MIM_STATUS_OFFSET, {21'h0, 1'b1, 7'h0, r ^ pr, 1'b0,
                                     a ^ pa});
         wr(`MIM_STATUS_OFFSET, 32'hFFFF_FFFF);
         {pa, pr} = {a, r};
      end
      // frequency output pulses and output two polarity
      wr(`MIM_MASK_OFFSET, 32'h0000_00E0);
      first = 1'b1;
      pn = 1'b0;
      for (int k = 0; k < 6; k++) begin
         n = 1'($urandom_range(1));
         freq_out_two_neg = n;
         {freq_out_one_pulse, freq_out_two_pulse} = 2'h0;
         tick(1);
         {freq_out_one_pulse, freq_out_two_pulse} = 2'h3;
         tick(3);
         check_irq(1'b1);
         rd_exp(`MIM_STATUS_OFFSET, {24'h0, 2'h3,
                                     ~first & (n ^ pn), 5'h0});
         wr(`MIM_STATUS_OFFSET, 32'hFFFF_FFFF);
         check_irq(1'b0);
         {first, pn} = {1'b0, n};
      end
      // let the last answers arrive
      for (int w = 0; w < 50 && exp_q.size() > 0; w++) tick(1);
      if (exp_q.size() > 0) n_mismatch++;
      complete_run();
   end
endmodule : testbench
